/* pkg/alr_pkg.sv */
`default_nettype none
package alr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ALR_OFF_ENTRY_THR = 8'h1F;
  localparam logic [7:0] ALR_OFF_EXIT_HYS = 8'h20;
  localparam logic [7:0] ALR_OFF_S1_LOW = 8'h21;
  localparam logic [7:0] ALR_OFF_S1_HIGH = 8'h22;
  localparam logic [7:0] ALR_OFF_S2_LOW = 8'h23;
  localparam logic [7:0] ALR_OFF_S2_HIGH = 8'h24;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [7:0] ALR_RST_ENTRY_THR = 8'h00;
  localparam logic [7:0] ALR_RST_EXIT_HYS = 8'h00;
  localparam logic [12:0] ALR_RST_RESULT = 13'h0000;
  localparam logic [7:0] ALR_RDATA_IDLE = 8'h00;
  localparam int ALR_RESULT_W = 13;
  localparam int ALR_HIGH_W = 5;
  localparam logic [2:0] ALR_HIGH_RSVD = 3'h0;
  // hysteresis step in tenths of nA; logic compares raw codes, so this is reference only
  localparam int ALR_HYS_STEP_NA10 = 5400;

  // ****************************************
  // timing
  // ****************************************
  localparam int ALR_CLK_MHZ = 250;
  localparam int ALR_REFRESH_MS = 80;
  localparam int ALR_REFRESH_CYCLES = ALR_REFRESH_MS * 1000 * ALR_CLK_MHZ;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } alr_reg_req_t;

  typedef struct packed {
    logic [ALR_RESULT_W-1:0] one;
    logic [ALR_RESULT_W-1:0] two;
  } alr_results_t;
endpackage
`default_nettype wire

/* logic/alr_refresh_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_refresh_timer import alr_pkg::*; #(
  parameter int PERIOD_CYCLES = ALR_REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  // event
  output logic tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic at_end;

  // restart from zero whenever sensing is switched off
  assign at_end = (count == 32'(PERIOD_CYCLES - 1));
  assign next_count = (!enable || at_end) ? 32'h00000000 : count + 32'h00000001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= enable && at_end;
    end
  end

  property p_tick_needs_enable;
    @(posedge clk) disable iff (!rst_n)
    tick |-> $past(enable);
  endproperty
  a_tick_needs_enable: assert property (p_tick_needs_enable) else $error("refresh tick while disabled");
endmodule
`default_nettype wire

/* logic/alr_readout.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_readout import alr_pkg::*; #(
  parameter int REFRESH_CYCLES = ALR_REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register access
  input wire alr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // light sensing
  input wire logic sense_enable,
  input wire logic [7:0] comp_level,
  input wire alr_results_t conv_sample,
  output logic dark_mode
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // settings registers
  // ****************************************
  logic [7:0] dark_entry_threshold;
  logic [7:0] dark_exit_hysteresis;
  logic wr_thr;
  logic wr_hys;

  assign wr_thr = reg_req.wr && (reg_req.addr == ALR_OFF_ENTRY_THR);
  assign wr_hys = reg_req.wr && (reg_req.addr == ALR_OFF_EXIT_HYS);

  // hysteresis code is kept raw; the linear current scale maps one code per step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dark_entry_threshold <= ALR_RST_ENTRY_THR;
      dark_exit_hysteresis <= ALR_RST_EXIT_HYS;
    end else begin
      if (wr_thr) begin
        dark_entry_threshold <= reg_req.wdata;
      end
      if (wr_hys) begin
        dark_exit_hysteresis <= reg_req.wdata;
      end
    end
  end

  // ****************************************
  // dark mode comparator
  // ****************************************
  logic [8:0] exit_level;
  logic below_entry;
  logic above_exit;
  logic next_dark_mode;

  // nine bits so a large threshold plus hysteresis cannot wrap
  assign exit_level = {1'b0, dark_entry_threshold} + {1'b0, dark_exit_hysteresis};
  assign below_entry = comp_level < dark_entry_threshold;
  assign above_exit = {1'b0, comp_level} > exit_level;
  assign next_dark_mode = dark_mode ? !above_exit : below_entry;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dark_mode <= 1'b0;
    end else begin
      dark_mode <= next_dark_mode;
    end
  end

  // ****************************************
  // conversion results
  // ****************************************
  logic refresh_tick;
  alr_results_t results;

  alr_refresh_timer #(
    .PERIOD_CYCLES(REFRESH_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .enable(sense_enable),
    .tick(refresh_tick)
  );

  // whole words are captured at once; a low/high byte pair read across a refresh tick can still mix conversions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      results <= {ALR_RST_RESULT, ALR_RST_RESULT};
    end else if (refresh_tick) begin
      results <= conv_sample;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = ALR_RDATA_IDLE;
    unique case (reg_req.addr)
      ALR_OFF_ENTRY_THR: next_rdata = dark_entry_threshold;
      ALR_OFF_EXIT_HYS: next_rdata = dark_exit_hysteresis;
      ALR_OFF_S1_LOW: next_rdata = results.one[7:0];
      ALR_OFF_S1_HIGH: next_rdata = {ALR_HIGH_RSVD, results.one[12:8]};
      ALR_OFF_S2_LOW: next_rdata = results.two[7:0];
      ALR_OFF_S2_HIGH: next_rdata = {ALR_HIGH_RSVD, results.two[12:8]};
      default: next_rdata = ALR_RDATA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ALR_RDATA_IDLE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_req.rd ? next_rdata : ALR_RDATA_IDLE;
      reg_rvalid <= reg_req.rd;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_dark_exit;
    @(posedge clk) disable iff (!rst_n)
    dark_mode && ({1'b0, comp_level} > exit_level) |=> !dark_mode;
  endproperty
  a_dark_exit: assert property (p_dark_exit) else $error("dark mode not left above exit level");

  property p_dark_entry;
    @(posedge clk) disable iff (!rst_n)
    !dark_mode && (comp_level < dark_entry_threshold) |=> dark_mode;
  endproperty
  a_dark_entry: assert property (p_dark_entry) else $error("dark mode not entered below threshold");

  property p_dark_hold;
    @(posedge clk) disable iff (!rst_n)
    $rose(dark_mode) |-> $past(comp_level) < $past(dark_entry_threshold);
  endproperty
  a_dark_hold: assert property (p_dark_hold) else $error("dark mode entered without cause");

  property p_hys_store;
    @(posedge clk) disable iff (!rst_n)
    wr_hys ##1 (reg_req.rd && reg_req.addr == ALR_OFF_EXIT_HYS && !reg_req.wr) |=>
      reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_hys_store: assert property (p_hys_store) else $error("hysteresis code not stored");

  property p_read_s1_low;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == ALR_OFF_S1_LOW |=> reg_rvalid && reg_rdata == $past(results.one[7:0]);
  endproperty
  a_read_s1_low: assert property (p_read_s1_low) else $error("sensor one low byte wrong");

  property p_read_s1_high;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == ALR_OFF_S1_HIGH |=>
      reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(results.one[12:8]);
  endproperty
  a_read_s1_high: assert property (p_read_s1_high) else $error("sensor one high byte wrong");

  property p_read_s2_low;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == ALR_OFF_S2_LOW |=> reg_rvalid && reg_rdata == $past(results.two[7:0]);
  endproperty
  a_read_s2_low: assert property (p_read_s2_low) else $error("sensor two low byte wrong");

  property p_read_s2_high;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == ALR_OFF_S2_HIGH |=>
      reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(results.two[12:8]);
  endproperty
  a_read_s2_high: assert property (p_read_s2_high) else $error("sensor two high byte wrong");

  property p_no_refresh_off;
    @(posedge clk) disable iff (!rst_n)
    !sense_enable ##1 !sense_enable |=> $stable(results);
  endproperty
  a_no_refresh_off: assert property (p_no_refresh_off) else $error("results changed while disabled");

  property p_pair_capture;
    @(posedge clk) disable iff (!rst_n)
    refresh_tick |=> results == $past(conv_sample);
  endproperty
  a_pair_capture: assert property (p_pair_capture) else $error("result words not captured whole");
endmodule
`default_nettype wire

/* dv/alr_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_readout_tb import alr_pkg::*;;
  // ****************************************
  // clock, reset and design
  // ****************************************
  localparam int N = 16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  alr_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic sense_enable = 1'b0;
  logic [7:0] comp_level = 8'hFF;
  alr_results_t conv_sample = '0;
  logic dark_mode;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] rd_val;

  always #2 clk = ~clk;

  alr_readout #(.REFRESH_CYCLES(N)) uut (
    .clk(clk),
    .nrst(nrst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .sense_enable(sense_enable),
    .comp_level(comp_level),
    .conv_sample(conv_sample),
    .dark_mode(dark_mode)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard: whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    reg_req <= '0;
    // idle edge so a following call never reassigns the request in this step
    @(negedge clk);
  endtask

  // read issued in the cycle right after the write must see the new value
  task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    reg_req <= '0;
    chk8("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk8("write then read", d, reg_rdata);
    @(negedge clk);
  endtask

  // answer lands one edge after the strobe; rvalid checked with data
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    reg_req <= '0;
    chk8("rvalid", 8'h01, {7'h00, reg_rvalid});
    d = reg_rdata;
    // answer stands one cycle only
    @(negedge clk);
    chk8("rvalid drop", 8'h00, {7'h00, reg_rvalid});
    chk8("rdata idle", 8'h00, reg_rdata);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd(a, rd_val);
    chk8($sformatf("reg %h", a), exp, rd_val);
  endtask

  task automatic chk_results(input logic [12:0] one, input logic [12:0] two);
    rd_chk(ALR_OFF_S1_LOW, one[7:0]);
    rd_chk(ALR_OFF_S1_HIGH, {3'h0, one[12:8]});
    rd_chk(ALR_OFF_S2_LOW, two[7:0]);
    rd_chk(ALR_OFF_S2_HIGH, {3'h0, two[12:8]});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_and_map();
    chk_results(13'h0000, 13'h0000);
    rd_chk(ALR_OFF_EXIT_HYS, 8'h00);
    rd_chk(8'h30, 8'h00);
    reg_wr(ALR_OFF_EXIT_HYS, 8'h7F);
    rd_chk(ALR_OFF_EXIT_HYS, 8'h7F);
    wr_then_rd(ALR_OFF_EXIT_HYS, 8'h2A);
    wr_then_rd(ALR_OFF_ENTRY_THR, 8'h15);
  endtask

  task automatic t_comparator();
    reg_wr(ALR_OFF_ENTRY_THR, 8'h40);
    reg_wr(ALR_OFF_EXIT_HYS, 8'h10);
    comp_level <= 8'h40;
    repeat (2) @(negedge clk);
    chk8("dark at thr", 8'h00, {7'h00, dark_mode});
    comp_level <= 8'h3F;
    repeat (2) @(negedge clk);
    chk8("dark below thr", 8'h01, {7'h00, dark_mode});
    // equal to the sum is not above it, so still dark
    comp_level <= 8'h50;
    repeat (2) @(negedge clk);
    chk8("dark at sum", 8'h01, {7'h00, dark_mode});
    comp_level <= 8'h51;
    repeat (2) @(negedge clk);
    chk8("office above sum", 8'h00, {7'h00, dark_mode});
    // sum past eight bits must not wrap to a small exit level
    reg_wr(ALR_OFF_ENTRY_THR, 8'hC0);
    reg_wr(ALR_OFF_EXIT_HYS, 8'h7F);
    comp_level <= 8'hBF;
    repeat (2) @(negedge clk);
    chk8("dark below high thr", 8'h01, {7'h00, dark_mode});
    comp_level <= 8'hFF;
    repeat (2) @(negedge clk);
    chk8("dark at top code", 8'h01, {7'h00, dark_mode});
  endtask

  task automatic t_refresh();
    conv_sample <= '{one: 13'h1ABC, two: 13'h0F5A};
    repeat (3 * N) @(negedge clk);
    chk_results(13'h0000, 13'h0000);
    sense_enable <= 1'b1;
    repeat (N + 4) @(negedge clk);
    sense_enable <= 1'b0;
    reg_wr(ALR_OFF_S1_LOW, 8'h55);
    chk_results(13'h1ABC, 13'h0F5A);
    conv_sample <= '{one: 13'h0543, two: 13'h1FFF};
    repeat (3 * N) @(negedge clk);
    chk_results(13'h1ABC, 13'h0F5A);
    sense_enable <= 1'b1;
    repeat (N + 4) @(negedge clk);
    chk_results(13'h0543, 13'h1FFF);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    nrst <= 1'b1;
    repeat (3) @(negedge clk);
    t_reset_and_map();
    t_comparator();
    t_refresh();
    wrap_up();
  end
endmodule
`default_nettype wire
